// ### logic/pmp_dev_end.sv
// device end: receive/transmit burst command policy, parity and clock-run
// What this block and the host end do
// R01: invalidate only with line size 8 or 16
// R02: invalidate only from line-aligned start address
// R03: invalidate only with a full line buffered
// R04: invalidate only with a line of room left
// R05: invalidate needs both enable bits set
// R06: otherwise deposit with plain memory write
// R07: invalidate moves whole lines, all bytes enabled
// R08: failed eligibility ends invalidate at line end
// R09: plain write ends at line if option set
// R10: read alignment only while option bit set
// R11: nearly full transmit fifo ends read at line
// R12: limited read slots hand over at lines
// R13: software sets line size 8/16 for alignment
// R14: read parity error plus response: error, bit 8
// R15: read parity error also sets bit 15
// R16: host releases clock-run before stopping clock
// R17: host drives clock-run low while clock runs
// R18: device pulls clock-run low to keep clock
// R19: host restores clock within half microsecond
// R20: clock-run disabled: device always claims clock
// R21: transmit slot limited to programmed transfer count
// R22: eligibility checked at burst start and lines
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module pmp_dev_end (
	input wire logic core_clk, // 200 MHz clock
	input wire logic reset, // synchronous, active high
	pmp_link_if.dev link, // bus side
	input wire logic [7:0] regAddr, // register byte address
	input wire logic [31:0] regWData, // register write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [31:0] regRData, // read data, cycle after strobe
	input wire logic [31:0] rxData, // receive fifo head word
	input wire logic [7:0] rxLevel, // receive fifo dwords held
	output logic rxPop, // head word taken
	input wire logic txNearFull, // transmit fifo almost full
	output logic txPush, // transmit word valid
	output logic [31:0] txData // transmit word
);
	// ************************************************************
	// registers and line geometry
	// ************************************************************
	logic [31:0] cmdReg_r, cfgReg_r; // command and configure bits
	logic [7:0] clsReg_r, txMax_r, txCnt_r; // line size, slot limit, transfers this slot
	logic [31:0] rxAddr_r, txAddr_r; // channel pointers
	logic [15:0] rxRoom_r, txLen_r; // receive room, transmit dwords left
	logic rxAct_r, txAct_r; // channels started
	logic stDpd_r, stDpe_r; // parity detected and detected-error flags
	pmp_pkg::pmp_dev_state_t state_r; // burst sequencer
	logic isRx_r, isMwi_r, lastRx_r; // burst kind, invalidate used, last served receive
	logic txHold_r; // transmit burst waits for a line to stop
	logic lineS1_r, lineS2_r; // clock-run sync stages
	logic clsOk, accept, raEn, readErr; // line size ok, beat taken, align on, bad read parity
	logic pickRx, pickTx, goWr, stWr; // channels wanting the bus, register hits
	logic txStop; // slot limit or nearly full fifo, latched until a line allows it
	logic [3:0] lineMask; // dword index within a line
	logic [31:0] nextAddr; // address after this beat
	assign clsOk = (clsReg_r == pmp_pkg::CLS_SMALL) || (clsReg_r == pmp_pkg::CLS_LARGE); // see R01
	assign lineMask = (clsReg_r == pmp_pkg::CLS_LARGE) ? pmp_pkg::MASK_LARGE : pmp_pkg::MASK_SMALL;
	assign accept = link.valid & link.ready;
	assign nextAddr = link.addr + pmp_pkg::ADDR_STEP;
	assign raEn = cfgReg_r[pmp_pkg::CFG_RALIGN_BIT]; // see R10
	assign pickRx = rxAct_r && (rxRoom_r != 16'h0000) && (rxLevel != 8'h00);
	assign pickTx = txAct_r && (txLen_r != 16'h0000) && !txNearFull;
	assign readErr = accept && !isRx_r && ((^link.rdData) != link.rdPar);
	assign goWr = regWr && regAddr == pmp_pkg::REG_GO;
	assign stWr = regWr && regAddr == pmp_pkg::REG_STAT;
	assign txStop = txHold_r || txNearFull // see R11
		|| (txMax_r != 8'h00 && txCnt_r + 8'h01 >= txMax_r); // see R21
	// true on a line boundary
	function automatic logic onLine(input logic [31:0] a);
		onLine = (a[5:2] & lineMask) == 4'h0;
	endfunction : onLine
	// all invalidate conditions for a line starting at a
	function automatic logic mwiOk(input logic [31:0] a);
		mwiOk = clsOk // see R01
			&& onLine(a) // see R02
			&& (rxLevel >= clsReg_r) // see R03
			&& (rxRoom_r >= {8'h00, clsReg_r}) // see R04
			&& cmdReg_r[pmp_pkg::CMD_MWI_BIT] && cfgReg_r[pmp_pkg::CFG_MWI_BIT]; // see R05
	endfunction : mwiOk
	// ************************************************************
	// software registers and channel state
	// ************************************************************
	// a write by software wins; channels stop once their count is spent
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmdReg_r <= pmp_pkg::RST_WORD;
			cfgReg_r <= pmp_pkg::RST_WORD;
			clsReg_r <= pmp_pkg::RST_WORD[7:0];
			txMax_r <= pmp_pkg::RST_WORD[7:0];
			rxAddr_r <= pmp_pkg::RST_WORD;
			txAddr_r <= pmp_pkg::RST_WORD;
			rxRoom_r <= pmp_pkg::RST_WORD[15:0];
			txLen_r <= pmp_pkg::RST_WORD[15:0];
			rxAct_r <= 1'b0;
			txAct_r <= 1'b0;
		end else begin
			if (regWr) begin
				case (regAddr)
					pmp_pkg::REG_CMD: cmdReg_r <= regWData;
					pmp_pkg::REG_CFG: cfgReg_r <= regWData;
					pmp_pkg::REG_CLS: clsReg_r <= regWData[7:0]; // see R13
					pmp_pkg::REG_TXMAX: txMax_r <= regWData[7:0];
					default: ; // pointers and counts below
				endcase
			end
			rxAddr_r <= (regWr && regAddr == pmp_pkg::REG_RXADDR) ? regWData
				: (accept && isRx_r) ? nextAddr : rxAddr_r;
			rxRoom_r <= (regWr && regAddr == pmp_pkg::REG_RXROOM) ? regWData[15:0]
				: (accept && isRx_r) ? rxRoom_r - 16'h0001 : rxRoom_r;
			txAddr_r <= (regWr && regAddr == pmp_pkg::REG_TXADDR) ? regWData
				: (accept && !isRx_r) ? nextAddr : txAddr_r;
			txLen_r <= (regWr && regAddr == pmp_pkg::REG_TXLEN) ? regWData[15:0]
				: (accept && !isRx_r) ? txLen_r - 16'h0001 : txLen_r;
			rxAct_r <= (goWr && regWData[pmp_pkg::GO_RX_BIT])
				|| (rxAct_r && !(rxRoom_r == 16'h0000 && state_r == pmp_pkg::DEV_IDLE));
			txAct_r <= (goWr && regWData[pmp_pkg::GO_TX_BIT])
				|| (txAct_r && !(txLen_r == 16'h0000 && state_r == pmp_pkg::DEV_IDLE));
		end
	end
	// ************************************************************
	// burst sequencer
	// ************************************************************
	// receive beats take two cycles: the head word is popped at load
	// and the fifo needs one cycle to show the next word and level
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= pmp_pkg::DEV_IDLE;
			link.frame <= 1'b0;
			link.valid <= 1'b0;
			link.cmd <= pmp_pkg::BUS_MW;
			link.addr <= pmp_pkg::RST_WORD;
			link.beN <= pmp_pkg::BE_ALL_N;
			link.wrData <= pmp_pkg::RST_WORD;
			link.wrPar <= 1'b0;
			isRx_r <= 1'b0;
			isMwi_r <= 1'b0;
			lastRx_r <= 1'b0;
			txHold_r <= 1'b0;
			txCnt_r <= 8'h00;
			rxPop <= 1'b0;
		end else begin
			rxPop <= 1'b0;
			link.beN <= pmp_pkg::BE_ALL_N; // see R07
			case (state_r)
				pmp_pkg::DEV_IDLE: begin
					link.frame <= pickRx || pickTx;
					link.valid <= pickRx || pickTx;
					state_r <= (pickRx || pickTx) ? pmp_pkg::DEV_DATA : pmp_pkg::DEV_IDLE;
					if (pickRx && (!pickTx || !lastRx_r)) begin
						// command chosen fresh at each burst start
						isMwi_r <= mwiOk(rxAddr_r); // see R22
						link.cmd <= mwiOk(rxAddr_r) ? pmp_pkg::BUS_MWI : pmp_pkg::BUS_MW; // see R06
						link.addr <= rxAddr_r;
						link.wrData <= rxData;
						link.wrPar <= ^rxData;
						rxPop <= 1'b1;
						isRx_r <= 1'b1;
					end else if (pickTx) begin
						link.cmd <= pmp_pkg::BUS_MR_MULT;
						link.addr <= txAddr_r;
						isRx_r <= 1'b0;
						isMwi_r <= 1'b0;
						txHold_r <= 1'b0;
						txCnt_r <= 8'h00; // see R21
					end
				end
				pmp_pkg::DEV_DATA: begin
					if (accept) begin
						link.addr <= nextAddr;
						if (isRx_r) begin
							link.valid <= 1'b0;
							state_r <= pmp_pkg::DEV_GAP;
						end else begin
							txCnt_r <= txCnt_r + 8'h01;
							// with alignment a wanted stop waits for a line
							if (txLen_r == 16'h0001
								|| (txStop && (!raEn || onLine(nextAddr)))) begin // see R12
								link.frame <= 1'b0;
								link.valid <= 1'b0;
								lastRx_r <= 1'b0;
								state_r <= pmp_pkg::DEV_IDLE;
							end else begin
								txHold_r <= txStop;
							end
						end
					end
				end
				pmp_pkg::DEV_GAP: begin
					// mid-line invalidate never stops: a line was buffered at its start
					if (rxRoom_r == 16'h0000 || rxLevel == 8'h00
						|| (onLine(link.addr) && (isMwi_r ? !mwiOk(link.addr) // see R08
						: cfgReg_r[pmp_pkg::CFG_TERM_BIT]))) begin // see R09
						link.frame <= 1'b0;
						lastRx_r <= 1'b1;
						state_r <= pmp_pkg::DEV_IDLE;
					end else begin
						link.wrData <= rxData;
						link.wrPar <= ^rxData;
						rxPop <= 1'b1;
						link.valid <= 1'b1;
						state_r <= pmp_pkg::DEV_DATA;
					end
				end
				default: state_r <= pmp_pkg::DEV_IDLE;
			endcase
		end
	end
	// ************************************************************
	// transmit delivery, parity, clock-run and register reads
	// ************************************************************
	// flags: a new error wins over a write-one clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			txPush <= 1'b0;
			txData <= pmp_pkg::RST_WORD;
			link.perrN <= 1'b1;
			stDpd_r <= 1'b0;
			stDpe_r <= 1'b0;
		end else begin
			txPush <= accept && !isRx_r;
			if (accept && !isRx_r) begin
				txData <= link.rdData;
			end
			link.perrN <= !(readErr && cmdReg_r[pmp_pkg::CMD_PER_BIT]); // see R14
			stDpd_r <= ((readErr || link.tgtPerr) && cmdReg_r[pmp_pkg::CMD_PER_BIT]) // see R14
				|| (stDpd_r && !(stWr && regWData[pmp_pkg::ST_DPD_BIT]));
			stDpe_r <= readErr || (stDpe_r && !(stWr && regWData[pmp_pkg::ST_DPE_BIT])); // see R15
		end
	end
	// any pending work holds the clock; the line is a pin, so sync it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link.devCkOeN <= 1'b0;
			link.devCkOut <= 1'b0;
			lineS1_r <= 1'b0;
			lineS2_r <= 1'b0;
		end else begin
			link.devCkOeN <= !(!cfgReg_r[pmp_pkg::CFG_CLKRUN_BIT] || rxAct_r || txAct_r // see R20
				|| rxLevel != 8'h00 || state_r != pmp_pkg::DEV_IDLE); // see R18
			lineS1_r <= link.ckLine;
			lineS2_r <= lineS1_r;
		end
	end
	// unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (reset) begin
			regRData <= pmp_pkg::RST_WORD;
		end else if (regRd) begin
			case (regAddr)
				pmp_pkg::REG_CMD: regRData <= cmdReg_r;
				pmp_pkg::REG_CFG: regRData <= cfgReg_r;
				pmp_pkg::REG_CLS: regRData <= {24'h000000, clsReg_r};
				pmp_pkg::REG_TXMAX: regRData <= {24'h000000, txMax_r};
				pmp_pkg::REG_STAT: regRData <= {16'h0000, stDpe_r, 6'h00, stDpd_r,
					5'h00, !lineS2_r, txAct_r, rxAct_r};
				pmp_pkg::REG_RXADDR: regRData <= rxAddr_r;
				pmp_pkg::REG_RXROOM: regRData <= {16'h0000, rxRoom_r};
				pmp_pkg::REG_TXADDR: regRData <= txAddr_r;
				pmp_pkg::REG_TXLEN: regRData <= {16'h0000, txLen_r};
				pmp_pkg::REG_GO: regRData <= {30'h00000000, txAct_r, rxAct_r};
				default: regRData <= pmp_pkg::RST_WORD;
			endcase
		end
	end
endmodule : pmp_dev_end

// ### logic/pmp_pkg.sv
// shared constants and types for the bus-master write/read policy block
package pmp_pkg;

	// ************************************************************
	// register byte addresses on the device's plain port
	// ************************************************************
	localparam logic [7:0] REG_CMD = 8'h00; // bus command bits
	localparam logic [7:0] REG_CFG = 8'h04; // configure byte 3 plus clock-run enable
	localparam logic [7:0] REG_CLS = 8'h08; // cache line size in dwords
	localparam logic [7:0] REG_TXMAX = 8'h0c; // transmit transfers per slot, 0 = no limit
	localparam logic [7:0] REG_STAT = 8'h10; // error flags and busy state
	localparam logic [7:0] REG_RXADDR = 8'h14; // receive buffer byte pointer
	localparam logic [7:0] REG_RXROOM = 8'h18; // receive buffer room in dwords
	localparam logic [7:0] REG_TXADDR = 8'h1c; // transmit buffer byte pointer
	localparam logic [7:0] REG_TXLEN = 8'h20; // transmit dwords still to fetch
	localparam logic [7:0] REG_GO = 8'h24; // start bits, reads back channel activity

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CMD_MWI_BIT = 4; // invalidate enable in command register
	localparam int CMD_PER_BIT = 6; // parity error response
	localparam int CFG_MWI_BIT = 0; // invalidate enable of configure command
	localparam int CFG_RALIGN_BIT = 2; // read alignment
	localparam int CFG_TERM_BIT = 3; // terminate write on cache line
	localparam int CFG_CLKRUN_BIT = 8; // clock-run support enable
	localparam int ST_RXBUSY_BIT = 0; // receive channel active
	localparam int ST_TXBUSY_BIT = 1; // transmit channel active
	localparam int ST_LINELOW_BIT = 2; // clock-run line seen low
	localparam int ST_DPD_BIT = 8; // data parity detected
	localparam int ST_DPE_BIT = 15; // detected parity error
	localparam int GO_RX_BIT = 0; // start receive channel
	localparam int GO_TX_BIT = 1; // start transmit channel

	// ************************************************************
	// values after reset and encodings
	// ************************************************************
	localparam logic [31:0] RST_WORD = 32'h0000_0000; // all registers clear
	localparam logic [7:0] CLS_SMALL = 8'h08; // 8-dword line
	localparam logic [7:0] CLS_LARGE = 8'h10; // 16-dword line
	localparam logic [3:0] MASK_SMALL = 4'h7; // dword index mask, small line
	localparam logic [3:0] MASK_LARGE = 4'hf; // dword index mask, large line
	localparam logic [3:0] BUS_MR_MULT = 4'hc; // memory read multiple
	localparam logic [3:0] BUS_MW = 4'h7; // memory write
	localparam logic [3:0] BUS_MWI = 4'hf; // memory write and invalidate
	localparam logic [3:0] BE_ALL_N = 4'h0; // all byte enables active (low)
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004; // one dword

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 5; // core_clk period
	localparam int RESTORE_MAX_NS = 500; // longest clock restore latency
	localparam int RESTORE_MAX_CYC = RESTORE_MAX_NS / CLK_PERIOD_NS; // rounded down
	localparam logic [2:0] HOST_REL_WAIT = 3'h3; // cycles to watch the line after release

	typedef enum logic [1:0] {DEV_IDLE, DEV_DATA, DEV_GAP} pmp_dev_state_t;
	typedef enum logic [1:0] {CK_RUN, CK_REL, CK_STOP} pmp_ck_state_t;

endpackage : pmp_pkg

// ### logic/pmp_link_if.sv
// link between the bus-master device end and the host memory end
`timescale 1ns/1ps
interface pmp_link_if;
	logic frame; // device: burst in progress
	logic [3:0] cmd; // device: bus command of the burst
	logic [31:0] addr; // device: byte address of the current beat
	logic [3:0] beN; // device: byte enables, active low
	logic valid; // device: beat presented (initiator ready)
	logic [31:0] wrData; // device: write data
	logic wrPar; // device: even parity of wrData
	logic perrN; // device: parity error, active low pulse
	logic ready; // host: target ready for the beat
	logic [31:0] rdData; // host: read data
	logic rdPar; // host: even parity of rdData
	logic tgtPerr; // host: write data parity error pulse
	logic devCkOeN; // device: clock-run drive enable, low drives
	logic devCkOut; // device: clock-run drive value
	logic hostCkOeN; // host: clock-run drive enable, low drives
	logic hostCkOut; // host: clock-run drive value
	logic ckLine; // resolved open-drain clock-run level

	// open drain with pull-up: low if either end drives low
	assign ckLine = ~((~devCkOeN & ~devCkOut) | (~hostCkOeN & ~hostCkOut));

	modport dev (
		output frame, cmd, addr, beN, valid, wrData, wrPar, perrN, devCkOeN, devCkOut,
		input ready, rdData, rdPar, tgtPerr, ckLine
	);
	modport host (
		input frame, cmd, addr, beN, valid, wrData, wrPar, perrN, devCkOeN, devCkOut,
		output ready, rdData, rdPar, tgtPerr, hostCkOeN, hostCkOut,
		input ckLine
	);
endinterface : pmp_link_if

// ### logic/pmp_host_end.sv
// host end: memory target for the device's bursts and clock-run control
`timescale 1ns/1ps
module pmp_host_end (
	input wire logic core_clk, // 200 MHz clock
	input wire logic reset, // synchronous, active high
	pmp_link_if.host link, // bus side
	input wire logic memStall, // hold off target ready
	input wire logic badParity, // corrupt parity on read and write checks
	input wire logic stopClkReq, // system wants to stop the clock
	output logic clkRunning, // clock considered running
	output logic wrBeat, // one write beat taken
	output logic [31:0] wrAddr, // its address
	output logic [3:0] wrCmd, // its command
	output logic [31:0] wrData // its data
);

	// ************************************************************
	// state
	// ************************************************************
	pmp_pkg::pmp_ck_state_t ck_r; // clock-run sequencer
	logic [2:0] relCnt_r; // cycles since release
	logic lineS1_r; // clock-run sync stage 1
	logic lineS2_r; // clock-run sync stage 2
	logic accept; // beat taken this edge
	logic isRead; // burst is a read
	logic [31:0] rdNxt; // next read word

	assign accept = link.valid & link.ready;
	assign isRead = link.cmd == pmp_pkg::BUS_MR_MULT;
	assign rdNxt = link.rdData + 32'h0000_0001;

	// ************************************************************
	// memory target
	// ************************************************************
	// read words are a running count; parity follows the word shown
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link.ready <= 1'b0;
			link.rdData <= pmp_pkg::RST_WORD;
			link.rdPar <= 1'b0;
			link.tgtPerr <= 1'b0;
			wrBeat <= 1'b0;
			wrAddr <= pmp_pkg::RST_WORD;
			wrCmd <= pmp_pkg::BUS_MW;
			wrData <= pmp_pkg::RST_WORD;
		end else begin
			link.ready <= !memStall;
			if (accept && isRead) begin
				link.rdData <= rdNxt;
				link.rdPar <= (^rdNxt) ^ badParity;
			end else if (badParity) begin
				link.rdPar <= !(^link.rdData);
			end else begin
				link.rdPar <= ^link.rdData;
			end
			link.tgtPerr <= accept && !isRead && (((^link.wrData) != link.wrPar) || badParity);
			wrBeat <= accept && !isRead;
			if (accept && !isRead) begin
				wrAddr <= link.addr;
				wrCmd <= link.cmd;
				wrData <= link.wrData;
			end
		end
	end

	// ************************************************************
	// clock-run sequencer
	// ************************************************************
	// release first, then watch the line; a device pull restarts it after the sync stages,
	// a few cycles, well inside RESTORE_MAX_CYC
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ck_r <= pmp_pkg::CK_RUN;
			relCnt_r <= 3'h0;
			link.hostCkOeN <= 1'b0;
			link.hostCkOut <= 1'b0;
			clkRunning <= 1'b1;
			lineS1_r <= 1'b0;
			lineS2_r <= 1'b0;
		end else begin
			lineS1_r <= link.ckLine;
			lineS2_r <= lineS1_r;
			link.hostCkOut <= 1'b0;
			case (ck_r)
				pmp_pkg::CK_RUN: begin
					link.hostCkOeN <= 1'b0; // see R17
					clkRunning <= 1'b1;
					relCnt_r <= 3'h0;
					if (stopClkReq) begin
						link.hostCkOeN <= 1'b1; // see R16
						ck_r <= pmp_pkg::CK_REL;
					end
				end
				pmp_pkg::CK_REL: begin
					relCnt_r <= relCnt_r + 3'h1;
					if (relCnt_r == pmp_pkg::HOST_REL_WAIT) begin
						if (!lineS2_r) begin
							link.hostCkOeN <= 1'b0;
							ck_r <= pmp_pkg::CK_RUN;
						end else begin
							clkRunning <= 1'b0;
							ck_r <= pmp_pkg::CK_STOP;
						end
					end
				end
				pmp_pkg::CK_STOP: begin
					if (!lineS2_r) begin
						link.hostCkOeN <= 1'b0; // see R19
						clkRunning <= 1'b1;
						ck_r <= pmp_pkg::CK_RUN;
					end
				end
				default: ck_r <= pmp_pkg::CK_RUN;
			endcase
		end
	end

endmodule : pmp_host_end

// ### verification/pmp_link_monitor.sv
// assertion monitor watching the link between device end and host end
`timescale 1ns/1ps
module pmp_link_monitor (
	input wire logic core_clk, // 200 MHz clock
	input wire logic reset, // sync reset
	input wire logic frame, // burst active
	input wire logic [3:0] cmd, // bus command
	input wire logic [31:0] addr, // beat address
	input wire logic [3:0] beN, // byte enables, low active
	input wire logic valid, // beat presented
	input wire logic ready, // target ready
	input wire logic [31:0] rdData, // read word
	input wire logic rdPar, // read parity
	input wire logic perrN, // parity error, low active
	input wire logic devCkOeN // clock-run drive, low drives
);
	// ******
	// last accepted beat, so a burst end can be judged
	// ******
	logic [31:0] lastAddr_r; // address of last accept
	logic [3:0] lastCmd_r; // command of last accept
	always_ff @(posedge core_clk) begin
		if (reset) begin
			lastAddr_r <= 32'h0;
			lastCmd_r <= 4'h0;
		end else if (valid && ready) begin
			lastAddr_r <= addr;
			lastCmd_r <= cmd;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_mwi_all_bytes: assert property (frame && valid && cmd == 4'hf |-> beN == 4'h0)
		else $error("invalidate beat without all byte enables");
	a_mwi_line_start: assert property ($rose(frame) && cmd == 4'hf |-> addr[4:0] == 5'h0)
		else $error("invalidate burst starts off a line boundary");
	a_cmd_held: assert property (frame && $past(frame) |-> cmd == $past(cmd))
		else $error("command changed inside a burst");
	a_mwi_line_end: assert property ($fell(frame) && lastCmd_r == 4'hf |-> lastAddr_r[4:2] == 3'h7)
		else $error("invalidate burst ended inside a line");
	a_beat_hold: assert property (valid && !ready |=> valid && $stable(addr))
		else $error("beat withdrawn before acceptance");
	a_perr_cause: assert property (!perrN |-> $past(valid && ready && cmd == 4'hc && (^rdData != rdPar)))
		else $error("parity error flagged without a bad read beat");
	a_clkrun_claim: assert property (frame && $past(frame) |-> !devCkOeN)
		else $error("clock-run line not held during a burst");
	a_read_step: assert property (frame && valid && cmd == 4'hc && $past(frame && valid && ready) |-> addr == $past(addr) + 32'h4)
		else $error("read address did not step by one dword");
endmodule : pmp_link_monitor

// ### verification/pci_master_write_read_policy_bench.sv
// self-checking bench: both link ends, register port and receive fifo model
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module pci_master_write_read_policy_bench;
	logic core_clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0; // clock, reset, strobes
	logic [7:0] regAddr = 8'h0, rxLevel = 8'h0; // register address, fifo level
	logic [31:0] regWData = 32'h0, rxData = 32'h0, regRData, txData, wrAddr, wrData; // data
	logic [31:0] rd, ex, expA, lastTx; // model values
	logic rxPop, txPush, wrBeat, clkRunning, first = 1'b0, frameD = 1'b0; // strobes, flags
	logic txNearFull = 1'b0, memStall = 1'b0, badParity = 1'b0, stopClkReq = 1'b0; // stimulus
	logic [3:0] wrCmd, expCmd; // taken and expected command
	int num_errors = 0, cmp_count = 0, cyc = 0, nBeats = 0, nBursts = 0, txCount = 0, perrCnt = 0;
	logic [31:0] rxq[$], expq[$]; // receive fifo and expected deposits
	// line size, offset, words, room, cmd en, cfg en, terminate, invalidate, bursts
	int tc[10][9] = '{'{8, 0, 16, 64, 1, 1, 0, 1, 1}, '{4, 0, 16, 64, 1, 1, 0, 0, 1},
		'{16, 0, 16, 64, 1, 1, 0, 1, 1}, '{8, 8, 16, 64, 1, 1, 0, 0, 1},
		'{8, 0, 7, 64, 1, 1, 0, 0, 1}, '{8, 0, 16, 7, 1, 1, 0, 0, 1},
		'{8, 0, 16, 64, 0, 1, 0, 0, 1}, '{8, 0, 16, 64, 1, 0, 0, 0, 1},
		'{8, 0, 16, 64, 0, 1, 1, 0, 2}, '{8, 0, 16, 12, 1, 1, 0, 1, 2}};
	pmp_link_if link ();
	pmp_dev_end pmp_dev_end_inst (.core_clk(core_clk), .reset(reset), .link(link),
		.regAddr(regAddr), .regWData(regWData), .regWr(regWr), .regRd(regRd), .regRData(regRData),
		.rxData(rxData), .rxLevel(rxLevel), .rxPop(rxPop), .txNearFull(txNearFull),
		.txPush(txPush), .txData(txData));
	pmp_host_end pmp_host_end_inst (.core_clk(core_clk), .reset(reset), .link(link),
		.memStall(memStall), .badParity(badParity), .stopClkReq(stopClkReq),
		.clkRunning(clkRunning), .wrBeat(wrBeat), .wrAddr(wrAddr), .wrCmd(wrCmd), .wrData(wrData));
	pmp_link_monitor pmp_link_monitor_inst (.core_clk(core_clk), .reset(reset), .frame(link.frame),
		.cmd(link.cmd), .addr(link.addr), .beN(link.beN), .valid(link.valid), .ready(link.ready),
		.rdData(link.rdData), .rdPar(link.rdPar), .perrN(link.perrN), .devCkOeN(link.devCkOeN));
	always #2.5 core_clk = ~core_clk;
	// ******
	// fifo model, random stalls, result comparison and hang guard
	// ******
	always @(posedge core_clk) begin
		cyc++;
		memStall <= ($urandom % 3) == 0;
		txNearFull <= ($urandom % 5) == 0;
		if (rxPop) void'(rxq.pop_front());
		rxData <= rxq.size() ? rxq[0] : ~rxData; // empty fifo shows a changing word
		rxLevel <= 8'(rxq.size());
		frameD <= link.frame;
		if (link.frame && !frameD) nBursts++;
		if (!link.perrN) perrCnt++;
		if (wrBeat) begin
			if (first) `CHK(wrCmd, expCmd)
			first = 1'b0;
			ex = expq.pop_front();
			`CHK(wrAddr, expA)
			`CHK(wrData, ex)
			expA += 32'h4;
			nBeats++;
		end
		if (txPush) begin
			if (txCount > 0) `CHK(txData, lastTx + 32'h1)
			lastTx = txData;
			txCount++;
		end
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rdReg(input logic [7:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 rd = regRData; // data holds until the next read strobe
	endtask : rdReg
	task automatic doReset;
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		rxq.delete();
		expq.delete();
		nBeats = 0;
		nBursts = 0;
		txCount = 0;
		perrCnt = 0;
	endtask : doReset
	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		void'($urandom(98));
		// receive deposits: command choice and burst splitting per table row
		foreach (tc[k]) begin
			doReset();
			wr(pmp_pkg::REG_CMD, 32'(tc[k][4] << pmp_pkg::CMD_MWI_BIT));
			wr(pmp_pkg::REG_CFG, 32'(tc[k][5] | (tc[k][6] << pmp_pkg::CFG_TERM_BIT)));
			wr(pmp_pkg::REG_CLS, 32'(tc[k][0]));
			expA = 32'h1000 + 32'(tc[k][1]);
			wr(pmp_pkg::REG_RXADDR, expA);
			wr(pmp_pkg::REG_RXROOM, 32'(tc[k][3]));
			for (int i = 0; i < tc[k][2]; i++) begin
				ex = $urandom;
				rxq.push_back(ex);
				if (i < tc[k][3]) expq.push_back(ex);
			end
			expCmd = tc[k][7] ? pmp_pkg::BUS_MWI : pmp_pkg::BUS_MW;
			first = 1'b1;
			wr(pmp_pkg::REG_GO, 32'h1);
			repeat (600) if (expq.size() || link.frame) @(posedge core_clk);
			`CHK(nBeats, (tc[k][2] < tc[k][3] ? tc[k][2] : tc[k][3]))
			`CHK(nBursts, tc[k][8])
			$display("receive test %0d done", k);
		end
		// transmit reads with corrupted parity, response off then on
		for (int p = 0; p < 2; p++) begin
			doReset();
			wr(pmp_pkg::REG_CMD, 32'(p << pmp_pkg::CMD_PER_BIT));
			wr(pmp_pkg::REG_CFG, 32'(p << pmp_pkg::CFG_RALIGN_BIT));
			wr(pmp_pkg::REG_CLS, 32'h8);
			wr(pmp_pkg::REG_TXMAX, 32'h5);
			wr(pmp_pkg::REG_TXADDR, 32'h2004);
			wr(pmp_pkg::REG_TXLEN, 32'h14);
			badParity <= 1'b1;
			wr(pmp_pkg::REG_GO, 32'h2);
			repeat (900) if (txCount < 20 || link.frame) @(posedge core_clk);
			badParity <= 1'b0;
			rdReg(pmp_pkg::REG_STAT);
			`CHK(rd[pmp_pkg::ST_DPD_BIT], p[0])
			`CHK(rd[pmp_pkg::ST_DPE_BIT], 1'b1)
			`CHK(perrCnt, p * 20)
			`CHK(txCount, 20)
			wr(pmp_pkg::REG_STAT, 32'h8100);
			rdReg(pmp_pkg::REG_STAT);
			`CHK(rd[15:8], 8'h0)
			$display("transmit test %0d done", p);
		end
		// clock-run: stop allowed when enabled, reclaimed once disabled
		doReset();
		rdReg(8'hfc);
		`CHK(rd, 32'h0)
		wr(pmp_pkg::REG_CFG, 32'h100);
		stopClkReq <= 1'b1;
		repeat (20) @(posedge core_clk);
		`CHK(clkRunning, 1'b0)
		wr(pmp_pkg::REG_CFG, 32'h0);
		repeat (10) @(posedge core_clk);
		`CHK(clkRunning, 1'b1)
		stopClkReq <= 1'b0;
		$display("clock-run test done");
		summarize();
	end
endmodule : pci_master_write_read_policy_bench
